/* File: hw/vmhr_bank.sv */
// Purpose: Holding register bank between the register master and the valve
// Assumes: Master front ends and fetch engine run on clk
// Notes: Answers are given only after any fetch that they wait on
`timescale 1ns/1ps

module vmhr_bank
  import vmhr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Master requests, serial and TCP alike
  input wire logic req_valid,
  input wire vmhr_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output vmhr_rsp_t rsp,
  // Fetch engine toward valve controller and sensors
  output logic cmd_valid,
  output vmhr_cmd_t cmd,
  input wire logic upd_valid,
  input wire vmhr_upd_t upd,
  input wire logic done_valid,
  input wire logic [15:0] done_code,
  // Real time clock, seconds since epoch
  input wire logic [31:0] now_sec,
  // Board controls
  output logic sanitize_start,
  output logic sanitize_cool,
  output logic sanitize_allowed,
  output logic [31:0] sanitize_limit,
  output logic board_scale_f,
  // Network identity
  output logic [15:0] mstp_instance,
  output logic [15:0] ip_instance,
  output logic [7:0] mstp_station,
  output logic [31:0] mstp_baud
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    vmhr_state_t st;
    logic primed;
    logic after_write;
    logic pend_read;
    logic [6:0] pend_addr;
    logic [6:0] win_lo;
    logic [6:0] win_hi;
    logic [6:0] grp_lo;
    logic [6:0] grp_hi;
    logic rsp_valid;
    vmhr_rsp_t rsp;
    logic cmd_valid;
    vmhr_cmd_t cmd;
    logic san_start;
    logic san_cool;
    logic san_allowed;
    logic scale_f;
    logic [15:0] mstp_inst;
    logic [15:0] ip_inst;
    logic [7:0] station;
    logic [31:0] baud;
    logic ready;
    logic [REG_COUNT-1:0][15:0] mem;
  } vmhr_core_t;
  vmhr_core_t c_reg;
  vmhr_core_t c_next;
  logic acc;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic in_rng(logic [6:0] a, logic [6:0] lo,
                                  logic [6:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // Read-only: result, live data, serial, manufacture stamp, firmware
  function automatic logic is_ro(logic [6:0] a);
    is_ro = in_rng(a, A_RESULT, A_PRIME_HI) ||
            in_rng(a, A_SERIAL, A_FW_HI);
  endfunction

  // Items that live in the valve and must be written through to it
  function automatic logic is_vcfg(logic [6:0] a);
    is_vcfg = in_rng(a, A_VSEL_LO, A_AL_HI) || (a == A_VALVE_SCALE) ||
              in_rng(a, A_SITE_LO, A_SITE_HI);
  endfunction

  // Writable stamp words; returns the upper word address in base
  function automatic logic is_stamp(logic [6:0] a, output logic [6:0] base);
    logic hit;
    hit = 1'b0;
    base = a;
    if ((a == A_COMM_STAMP) || (a == A_SAN_STAMP) || (a == A_MAINT_STAMP))
    begin
      hit = 1'b1;
    end
    else if ((a == A_COMM_STAMP + 7'h01) || (a == A_SAN_STAMP + 7'h01) ||
             (a == A_MAINT_STAMP + 7'h01))
    begin
      hit = 1'b1;
      base = a - 7'h01;
    end
    is_stamp = hit;
  endfunction

  // Span of values that one configuration write may disturb
  function automatic logic [13:0] grp_of(logic [6:0] a);
    if (in_rng(a, A_VSEL_LO, A_VSEL_HI))
    begin
      grp_of = {A_VSEL_LO, A_AL_HI};
    end
    else if (in_rng(a, A_SP_LO, A_SP_HI))
    begin
      grp_of = {A_SP_LO, A_SP_HI};
    end
    else if (in_rng(a, A_AL_LO, A_AL_HI))
    begin
      grp_of = {A_AL_LO, A_AL_HI};
    end
    else if (a == A_VALVE_SCALE)
    begin
      grp_of = {A_VALVE_SCALE, A_VALVE_SCALE};
    end
    else
    begin
      grp_of = {A_SITE_LO, A_SITE_HI};
    end
  endfunction

  assign acc = req_valid && req_ready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [6:0] sb;
    logic [13:0] g;
    sb = 7'h00;
    g = 14'h0000;
    c_next = c_reg;
    c_next.rsp_valid = 1'b0;
    c_next.cmd_valid = 1'b0;
    c_next.san_start = 1'b0;
    c_next.san_cool = 1'b0;
    case (c_reg.st)
      S_IDLE:
      begin
        // Same map for both front ends; the tcp bit is not decoded
        if (acc && (req.addr > A_LAST))
        begin
          c_next.rsp_valid = 1'b1;
          c_next.rsp = '{status: ST_UNMAPPED, rdata: WORD_ZERO};
        end
        else if (acc && !req.write)
        begin
          // Once primed, configuration stays cached and only live data is refetched
          c_next.st = S_WAIT;
          c_next.pend_read = 1'b1;
          c_next.pend_addr = req.addr;
          c_next.cmd_valid = 1'b1;
          c_next.cmd.addr = req.addr;
          c_next.cmd.data = WORD_ZERO;
          c_next.cmd.scale_f = c_reg.mem[A_BOARD_SCALE][0];
          if (!c_reg.primed)
          begin
            c_next.cmd.kind = FK_ALL;
            c_next.win_lo = A_PRIME_LO;
            c_next.win_hi = A_SITE_HI;
          end
          else
          begin
            c_next.cmd.kind = FK_PRIME;
            c_next.win_lo = A_PRIME_LO;
            c_next.win_hi = A_PRIME_HI;
          end
          c_next.cmd.lo = c_next.win_lo;
          c_next.cmd.hi = c_next.win_hi;
        end
        else if (acc && (req.addr == A_REFRESH))
        begin
          // Data ignored and nothing stored
          c_next.st = S_WAIT;
          c_next.pend_read = 1'b0;
          c_next.cmd_valid = 1'b1;
          c_next.cmd.kind = FK_ALL;
          c_next.cmd.addr = req.addr;
          c_next.cmd.data = WORD_ZERO;
          c_next.cmd.scale_f = c_reg.mem[A_BOARD_SCALE][0];
          c_next.win_lo = A_PRIME_LO;
          c_next.win_hi = A_SITE_HI;
          c_next.cmd.lo = A_PRIME_LO;
          c_next.cmd.hi = A_SITE_HI;
        end
        else if (acc && is_ro(req.addr))
        begin
          // Manufacture stamp falls here too
          c_next.rsp_valid = 1'b1;
          c_next.rsp = '{status: ST_REFUSED, rdata: WORD_ZERO};
        end
        else if (acc && is_stamp(req.addr, sb))
        begin
          // Upper word at the lower address
          c_next.mem[sb] = now_sec[31:16];
          c_next.mem[sb + 7'h01] = now_sec[15:0];
          c_next.rsp_valid = 1'b1;
          c_next.rsp = '{status: ST_OK, rdata: WORD_ZERO};
        end
        else if (acc && (req.addr == A_SAN_ARM))
        begin
          // Blocked unless the board permits it
          c_next.san_start = c_reg.san_allowed;
          c_next.rsp_valid = 1'b1;
          c_next.rsp.status = c_reg.san_allowed ? ST_OK : ST_REFUSED;
          c_next.rsp.rdata = WORD_ZERO;
        end
        else if (acc && (req.addr == A_SAN_COOL))
        begin
          c_next.san_cool = 1'b1;
          c_next.rsp_valid = 1'b1;
          c_next.rsp = '{status: ST_OK, rdata: WORD_ZERO};
        end
        else if (acc && is_vcfg(req.addr))
        begin
          // Written through; the group refetch follows
          g = grp_of(req.addr);
          c_next.st = S_WAIT;
          c_next.pend_read = 1'b0;
          c_next.after_write = 1'b1;
          c_next.grp_lo = g[13:7];
          c_next.grp_hi = g[6:0];
          c_next.win_lo = A_RESULT;
          c_next.win_hi = A_REFRESH;
          c_next.cmd_valid = 1'b1;
          c_next.cmd.kind = FK_WRITE;
          c_next.cmd.addr = req.addr;
          c_next.cmd.data = req.wdata;
          c_next.cmd.lo = g[13:7];
          c_next.cmd.hi = g[6:0];
          c_next.cmd.scale_f = c_reg.mem[A_BOARD_SCALE][0];
        end
        else if (acc)
        begin
          // Board-level settings, limit held in minutes
          c_next.mem[req.addr] = req.wdata;
          c_next.rsp_valid = 1'b1;
          c_next.rsp = '{status: ST_OK, rdata: WORD_ZERO};
        end
      end
      S_WAIT:
      begin
        // Only the window of the current fetch, and the result word at done, may change
        if (upd_valid && in_rng(upd.addr, c_reg.win_lo, c_reg.win_hi))
        begin
          c_next.mem[upd.addr] = upd.data;
        end
        if (done_valid)
        begin
          c_next.mem[A_RESULT] = done_code;
          if (c_reg.after_write)
          begin
            c_next.after_write = 1'b0;
            c_next.win_lo = c_reg.grp_lo;
            c_next.win_hi = c_reg.grp_hi;
            c_next.cmd_valid = 1'b1;
            c_next.cmd.kind = FK_GROUP;
            c_next.cmd.lo = c_reg.grp_lo;
            c_next.cmd.hi = c_reg.grp_hi;
            c_next.cmd.data = WORD_ZERO;
          end
          else
          begin
            c_next.st = S_IDLE;
            if (c_reg.cmd.kind == FK_ALL)
            begin
              c_next.primed = 1'b1;
            end
            c_next.rsp_valid = 1'b1;
            c_next.rsp.status = ST_OK;
            c_next.rsp.rdata =
              c_reg.pend_read ? c_next.mem[c_reg.pend_addr] : WORD_ZERO;
          end
        end
      end
      default:
      begin
        c_next.st = S_IDLE;
      end
    endcase
    // Write-only words never hold data
    c_next.mem[A_REFRESH] = WORD_ZERO;
    c_next.mem[A_SAN_ARM] = WORD_ZERO;
    c_next.mem[A_SAN_COOL] = WORD_ZERO;
    c_next.san_allowed = (c_next.mem[A_SAN_ALLOW] != WORD_ZERO);
    c_next.scale_f = c_next.mem[A_BOARD_SCALE][0];
    c_next.ready = (c_next.st == S_IDLE) && !c_next.rsp_valid;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      c_reg <= '0;
      c_reg.st <= S_IDLE;
      c_reg.ready <= 1'b1;
      c_reg.scale_f <= SCALE_C;
      c_reg.mstp_inst <= NET_MSTP_INST;
      c_reg.ip_inst <= NET_IP_INST;
      c_reg.station <= NET_STATION;
      c_reg.baud <= NET_BAUD;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign req_ready = c_reg.ready;
  assign rsp_valid = c_reg.rsp_valid;
  assign rsp = c_reg.rsp;
  assign cmd_valid = c_reg.cmd_valid;
  assign cmd = c_reg.cmd;
  assign sanitize_start = c_reg.san_start;
  assign sanitize_cool = c_reg.san_cool;
  assign sanitize_allowed = c_reg.san_allowed;
  assign sanitize_limit = {c_reg.mem[A_SAN_LIMIT],
                           c_reg.mem[A_SAN_LIMIT + 7'h01]};
  assign board_scale_f = c_reg.scale_f;
  assign mstp_instance = c_reg.mstp_inst;
  assign ip_instance = c_reg.ip_inst;
  assign mstp_station = c_reg.station;
  assign mstp_baud = c_reg.baud;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  first_fetch_a: assert property (
    (acc && !req.write && req.addr <= A_LAST && !c_reg.primed)
      |=> (cmd_valid && cmd.kind == FK_ALL && !rsp_valid))
    else $error("first read did not fetch all");
  later_fetch_a: assert property (
    (acc && !req.write && req.addr <= A_LAST && c_reg.primed)
      |=> (cmd_valid && cmd.kind == FK_PRIME && cmd.hi == A_PRIME_HI))
    else $error("later read not limited to prime data");
  cache_kept_a: assert property (
    (c_reg.st == S_WAIT && cmd.kind == FK_PRIME)
      |=> $stable(c_reg.mem[A_SERIAL]) && $stable(c_reg.mem[A_SITE_LO]))
    else $error("cached item changed during prime fetch");
  refresh_all_a: assert property (
    (acc && req.write && req.addr == A_REFRESH)
      |=> cmd_valid && cmd.kind == FK_ALL)
    else $error("refresh write did not refetch all");
  refresh_zero_a: assert property (
    c_reg.mem[A_REFRESH] == WORD_ZERO && c_reg.mem[A_SAN_ARM] == WORD_ZERO)
    else $error("write-only word holds data");
  group_refetch_a: assert property (
    (c_reg.st == S_WAIT && c_reg.after_write && done_valid)
      |=> cmd_valid && cmd.kind == FK_GROUP && c_reg.st == S_WAIT)
    else $error("no group refetch after configuration write");
  result_code_a: assert property (
    done_valid |=> c_reg.mem[A_RESULT] == $past(done_code))
    else $error("result register missed controller code");
  stamp_load_a: assert property (
    (acc && req.write && req.addr == A_SAN_STAMP + 7'h01)
      |=> c_reg.mem[A_SAN_STAMP] == $past(now_sec[31:16]) &&
          c_reg.mem[A_SAN_STAMP + 7'h01] == $past(now_sec[15:0]))
    else $error("stamp not loaded with current time");
  mfg_refuse_a: assert property (
    (acc && req.write && req.addr == A_MFG_STAMP)
      |=> rsp_valid && rsp.status == ST_REFUSED &&
          $stable(c_reg.mem[A_MFG_STAMP]))
    else $error("manufacture stamp write not refused");
  arm_gate_a: assert property (
    (acc && req.write && req.addr == A_SAN_ARM)
      |=> sanitize_start == $past(sanitize_allowed))
    else $error("sanitize start not gated by permit");
  scale_track_a: assert property (
    (acc && req.write && req.addr == A_BOARD_SCALE)
      |=> board_scale_f == $past(req.wdata[0]))
    else $error("board scale output out of step");
  net_ident_a: assert property (
    mstp_instance == NET_MSTP_INST && ip_instance == NET_IP_INST &&
    mstp_station == NET_STATION && mstp_baud == NET_BAUD)
    else $error("network identity changed");

endmodule

/* File: hw/vmhr_pkg.sv */
// Purpose: Constants and carriers for the valve monitor holding registers
// Assumes: One 16-bit word per register, addresses as the master sees them
// Notes: Shared by the register bank and its bench
//
// Contract
// - First read fetches everything before answering
// - Later reads refresh prime data, sensors only
// - Valve configuration served from cached copy
// - Refresh register write refetches all values
// - Refresh write stores nothing, data ignored
// - Configuration write refetches its affected group
// - Result register holds last controller code
// - Result codes follow controller list: 91,93,96
// - Timestamps are 32-bit epoch seconds, two words
// - Timestamp write loads current time, data ignored
// - Manufacture timestamp refuses writes
// - Scale code: 1 Fahrenheit, 0 Celsius
// - Valve scale changes valve display only
// - Board scale sets every reported temperature
// - Site text ASCII, 39 to 46, unterminated
// - Sanitize limit in minutes, registers 48-49
// - 53 arms sanitizing, 54 starts cool-down
// - Register 47 permits sanitizing at board level
// - Instances: 12 token-passing net, 11 IP
// - Token-passing station 11, 38400 baud
// - TCP and serial share one map
// - Register 0 write-only refresh trigger

// ****************************************************************
// Package
// ****************************************************************
package vmhr_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned REG_COUNT = 65;

  // Register addresses
  localparam logic [6:0] A_REFRESH = 7'h00;
  localparam logic [6:0] A_RESULT = 7'h01;
  localparam logic [6:0] A_PRIME_LO = 7'h02;
  localparam logic [6:0] A_PRIME_HI = 7'h16;
  localparam logic [6:0] A_VSEL_LO = 7'h17;
  localparam logic [6:0] A_VSEL_HI = 7'h18;
  localparam logic [6:0] A_SP_LO = 7'h19;
  localparam logic [6:0] A_SP_HI = 7'h1c;
  localparam logic [6:0] A_AL_LO = 7'h1d;
  localparam logic [6:0] A_AL_HI = 7'h1f;
  localparam logic [6:0] A_SERIAL = 7'h20;
  localparam logic [6:0] A_MFG_STAMP = 7'h22;
  localparam logic [6:0] A_FW_HI = 7'h25;
  localparam logic [6:0] A_VALVE_SCALE = 7'h26;
  localparam logic [6:0] A_SITE_LO = 7'h27;
  localparam logic [6:0] A_SITE_HI = 7'h2e;
  localparam logic [6:0] A_SAN_ALLOW = 7'h2f;
  localparam logic [6:0] A_SAN_LIMIT = 7'h30;
  localparam logic [6:0] A_CALIB = 7'h32;
  localparam logic [6:0] A_COMM_STAMP = 7'h33;
  localparam logic [6:0] A_SAN_ARM = 7'h35;
  localparam logic [6:0] A_SAN_COOL = 7'h36;
  localparam logic [6:0] A_SAN_OP = 7'h37;
  localparam logic [6:0] A_SAN_STAMP = 7'h38;
  localparam logic [6:0] A_MAINT_OP = 7'h3a;
  localparam logic [6:0] A_MAINT_STAMP = 7'h3b;
  localparam logic [6:0] A_BOARD_SCALE = 7'h3d;
  localparam logic [6:0] A_VALVE_KIND = 7'h3e;
  localparam logic [6:0] A_MIX_SIZE = 7'h3f;
  localparam logic [6:0] A_RET_SIZE = 7'h40;
  localparam logic [6:0] A_LAST = 7'h40;

  // Controller result codes
  localparam logic [15:0] RC_OK = 16'h0000;
  localparam logic [15:0] RC_INCOMPLETE = 16'h005b;
  localparam logic [15:0] RC_BAD_SUM_AT_CTRL = 16'h005d;
  localparam logic [15:0] RC_VALVE_TIMEOUT = 16'h0060;

  // Temperature scale codes
  localparam logic SCALE_C = 1'b0;
  localparam logic SCALE_F = 1'b1;

  // Network identity defaults
  localparam logic [15:0] NET_MSTP_INST = 16'h000c;
  localparam logic [15:0] NET_IP_INST = 16'h000b;
  localparam logic [7:0] NET_STATION = 8'h0b;
  localparam logic [31:0] NET_BAUD = 32'h00009600;

  // Answer status
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_REFUSED = 2'h1;
  localparam logic [1:0] ST_UNMAPPED = 2'h2;

  localparam logic [15:0] WORD_ZERO = 16'h0000;

  typedef enum logic [1:0] {FK_ALL, FK_PRIME, FK_GROUP, FK_WRITE} vmhr_kind_t;

  typedef enum logic [1:0] {S_IDLE, S_WAIT} vmhr_state_t;

  typedef struct packed {
    logic write;
    logic tcp;
    logic [6:0] addr;
    logic [15:0] wdata;
  } vmhr_req_t;

  typedef struct packed {
    logic [1:0] status;
    logic [15:0] rdata;
  } vmhr_rsp_t;

  typedef struct packed {
    vmhr_kind_t kind;
    logic [6:0] addr;
    logic [15:0] data;
    logic [6:0] lo;
    logic [6:0] hi;
    logic scale_f;
  } vmhr_cmd_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] data;
  } vmhr_upd_t;

endpackage

/* File: test/tb_valve_monitor_holding_regs.sv */
// Purpose: Self-checking bench for the holding register bank
// Assumes: Master requests one at a time, driven at the falling edge
// Notes: Expected values come from the register map and the model
`timescale 1ns/1ps

module tb_valve_monitor_holding_regs
  import vmhr_pkg::*;
;
  logic clk, rst_b, req_valid, req_ready, rsp_valid, cmd_valid;
  logic upd_valid, done_valid, sanitize_start, sanitize_cool;
  logic sanitize_allowed, board_scale_f, slow, bump, tcp_sel;
  logic [15:0] done_code, code_in, mstp_instance, ip_instance;
  logic [31:0] sanitize_limit, mstp_baud, stamp;
  logic [31:0] now_sec = 32'h5f5e1000;
  logic [7:0] mstp_station;
  logic [8:0] fetch_n;
  vmhr_req_t req;
  vmhr_rsp_t rsp;
  vmhr_cmd_t cmd, first_cmd;
  vmhr_upd_t upd;
  int bad_count, check_count, start_cnt, cool_cnt;
  logic [15:0] codes [4] = '{16'h005b, 16'h005d, 16'h0060, 16'h0000};
  logic [6:0] stamps [3] = '{7'h33, 7'h38, 7'h3b};

  vmhr_bank dut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .cmd_valid(cmd_valid), .cmd(cmd), .upd_valid(upd_valid), .upd(upd),
    .done_valid(done_valid), .done_code(done_code), .now_sec(now_sec),
    .sanitize_start(sanitize_start), .sanitize_cool(sanitize_cool),
    .sanitize_allowed(sanitize_allowed), .sanitize_limit(sanitize_limit),
    .board_scale_f(board_scale_f), .mstp_instance(mstp_instance),
    .ip_instance(ip_instance), .mstp_station(mstp_station),
    .mstp_baud(mstp_baud));

  vmhr_valve_model valve (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .upd_valid(upd_valid), .upd(upd), .done_valid(done_valid),
    .done_code(done_code), .code_in(code_in), .slow(slow), .bump(bump),
    .fetch_n(fetch_n), .first_cmd(first_cmd));

  // ****************************************************************
  // Clock, time of day and pulse counters
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(negedge clk)
    now_sec <= now_sec + 32'h00000001;

  // Counted at the falling edge, where the pulses have settled
  always @(negedge clk)
  begin
    if (sanitize_start === 1'b1)
      start_cnt++;
    if (sanitize_cool === 1'b1)
      cool_cnt++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      bad_count++;
    end
  endtask

  // One master access; write answers carry no data worth comparing
  // Holding registers only, addressed from zero
  task automatic acc(input logic wr, input logic [6:0] a,
    input logic [15:0] d, input logic [1:0] st, input logic [15:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{write: wr, tcp: tcp_sel, addr: a, wdata: d};
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    // Only writes load the stamp, so a read keeps the expected time
    #1;
    if (wr)
      stamp = now_sec;
    if (n >= 100)
      n = 2000;
    @(negedge clk);
    req_valid = 1'b0;
    req = '{write: ~wr, tcp: ~tcp_sel, addr: ~a, wdata: ~d};
    while (rsp_valid !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (rsp_valid !== 1'b1 || n >= 2000)
    begin
      bad_count++;
      wrap_up();
    end
    else
      check({rsp.status, wr ? 16'h0000 : rsp.rdata}, {st, exp});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    code_in = 16'h0000;
    slow = 1'b0;
    bump = 1'b0;
    tcp_sel = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    check(mstp_instance, 16'h000c);
    check(ip_instance, 16'h000b);
    check(mstp_station, 8'h0b);
    check(mstp_baud, 32'h00009600);
    acc(1'b0, 7'h20, 16'h0000, ST_OK, 16'h4020);
    check({first_cmd.kind, first_cmd.lo, first_cmd.hi},
      {FK_ALL, 7'h02, 7'h2e});
    bump = 1'b1;
    acc(1'b0, 7'h20, 16'h0000, ST_OK, 16'h4020);
    acc(1'b0, 7'h02, 16'h0000, ST_OK, {fetch_n + 9'h001, 7'h02});
    acc(1'b1, 7'h00, 16'hbeef, ST_OK, 16'h0000);
    bump = 1'b0;
    tcp_sel = 1'b1;
    acc(1'b0, 7'h20, 16'h0000, ST_OK, 16'hc020);
    tcp_sel = 1'b0;
    slow = 1'b1;
    acc(1'b1, 7'h19, 16'h0123, ST_OK, 16'h0000);
    acc(1'b0, 7'h19, 16'h0000, ST_OK, 16'h0123);
    slow = 1'b0;
    foreach (codes[i])
    begin
      code_in = codes[i];
      acc(1'b0, 7'h01, 16'h0000, ST_OK, codes[i]);
    end
    acc(1'b1, 7'h01, 16'h1111, ST_REFUSED, 16'h0000);
    foreach (stamps[i])
    begin
      acc(1'b1, stamps[i] + 7'h01, 16'hffff, ST_OK, 16'h0000);
      acc(1'b0, stamps[i], 16'h0000, ST_OK, stamp[31:16]);
      acc(1'b0, stamps[i] + 7'h01, 16'h0000, ST_OK, stamp[15:0]);
    end
    acc(1'b1, 7'h22, 16'h0001, ST_REFUSED, 16'h0000);
    acc(1'b1, 7'h3d, 16'h0001, ST_OK, 16'h0000);
    check(board_scale_f, SCALE_F);
    acc(1'b1, 7'h26, 16'h0000, ST_OK, 16'h0000);
    check(board_scale_f, SCALE_F);
    acc(1'b1, 7'h3d, 16'h0000, ST_OK, 16'h0000);
    check(board_scale_f, SCALE_C);
    acc(1'b1, 7'h35, 16'h0001, ST_REFUSED, 16'h0000);
    check(start_cnt, 0);
    acc(1'b1, 7'h2f, 16'h0001, ST_OK, 16'h0000);
    check(sanitize_allowed, 1'b1);
    acc(1'b1, 7'h35, 16'h0001, ST_OK, 16'h0000);
    acc(1'b1, 7'h36, 16'h0001, ST_OK, 16'h0000);
    @(negedge clk);
    check({start_cnt[15:0], cool_cnt[15:0]}, 32'h00010001);
    acc(1'b1, 7'h30, 16'h0001, ST_OK, 16'h0000);
    acc(1'b1, 7'h31, 16'h00a0, ST_OK, 16'h0000);
    check(sanitize_limit, 32'h000100a0);
    acc(1'b1, 7'h27, 16'h4142, ST_OK, 16'h0000);
    acc(1'b1, 7'h2e, 16'h4748, ST_OK, 16'h0000);
    acc(1'b0, 7'h27, 16'h0000, ST_OK, 16'h4142);
    acc(1'b0, 7'h2e, 16'h0000, ST_OK, 16'h4748);
    acc(1'b0, 7'h41, 16'h0000, ST_UNMAPPED, 16'h0000);
    acc(1'b1, 7'h7f, 16'h0001, ST_UNMAPPED, 16'h0000);
    wrap_up();
  end
endmodule

/* File: test/vmhr_valve_model.sv */
// Purpose: Behavioural valve controller and sensor fetch engine
// Assumes: One command at a time, each closed by one done pulse
// Notes: Prime words change with every fetch, config words do not
`timescale 1ns/1ps

module vmhr_valve_model
  import vmhr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Fetch port
  input wire logic cmd_valid,
  input wire vmhr_cmd_t cmd,
  output logic upd_valid,
  output vmhr_upd_t upd,
  output logic done_valid,
  output logic [15:0] done_code,
  // Bench controls
  input wire logic [15:0] code_in,
  input wire logic slow,
  input wire logic bump,
  output logic [8:0] fetch_n,
  output vmhr_cmd_t first_cmd
);
  logic [15:0] mem [0:127];
  vmhr_cmd_t c;

  // ****************************************************************
  // Command service
  // ****************************************************************
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 16'h4000 | 16'(i);
    upd_valid = 1'b0;
    upd = '0;
    done_valid = 1'b0;
    done_code = 16'h0000;
    fetch_n = '0;
    first_cmd = '0;
    forever
    begin
      @(negedge clk);
      if (cmd_valid === 1'b1)
      begin
        c = cmd;
        if (fetch_n == 9'h000)
          first_cmd = c;
        fetch_n = fetch_n + 9'h001;
        // Slow mode stands for a valve that answers late
        repeat (slow ? 9 : 1) @(posedge clk);
        if (c.kind == FK_WRITE)
          mem[c.addr] = c.data;
        else
          for (int a = int'(c.lo); a <= int'(c.hi); a++)
          begin
            upd_valid <= 1'b1;
            upd.addr <= 7'(a);
            if (a <= int'(A_PRIME_HI))
              upd.data <= {fetch_n, 7'(a)};
            else
              upd.data <= mem[a] ^ (bump ? 16'h8000 : 16'h0000);
            @(posedge clk);
          end
        // Released bus carries the last word inverted after a fetch; a write command inverts it back
        upd_valid <= 1'b0;
        upd.data <= ~upd.data;
        done_valid <= 1'b1;
        done_code <= code_in;
        @(posedge clk);
        done_valid <= 1'b0;
      end
    end
  end
endmodule
